/* File: hw/ars_pkg.sv */
package ars_pkg;

	// Register byte offsets on the Avalon-MM slave
	localparam logic [5:0] ARS_REG_CTRL = 6'h00;
	localparam logic [5:0] ARS_REG_DEAD = 6'h04;
	localparam logic [5:0] ARS_REG_RECLAIM = 6'h08;
	localparam logic [5:0] ARS_REG_CUTOUT = 6'h0c;
	localparam logic [5:0] ARS_REG_PH_DLY = 6'h10;
	localparam logic [5:0] ARS_REG_EF_DLY = 6'h14;
	localparam logic [5:0] ARS_REG_STATUS = 6'h18;
	localparam logic [5:0] ARS_REG_IRQ_STAT = 6'h1c;
	localparam logic [5:0] ARS_REG_IRQ_CLR = 6'h20;
	localparam logic [5:0] ARS_REG_IRQ_EN = 6'h24;

	// Timing: all sequence timers count a 1 ms tick
	localparam int ARS_CLK_HZ = 50000000;
	localparam int ARS_TICK_MS = 1;
	localparam int ARS_TICK_CYC = ARS_CLK_HZ / 1000 * ARS_TICK_MS;
	localparam int ARS_TW = 20;
	localparam int ARS_PICKUP_DLY_S = 300;
	localparam logic [ARS_TW-1:0] ARS_PICKUP_DLY_RST =
		ARS_TW'(ARS_PICKUP_DLY_S * 1000 / ARS_TICK_MS);
	localparam logic [ARS_TW-1:0] ARS_DEAD_RST = 20'h001f4;
	localparam logic [ARS_TW-1:0] ARS_RECLAIM_RST = 20'h02710;
	localparam logic [ARS_TW-1:0] ARS_CUTOUT_RST = 20'h01388;

	// Shot numbering
	localparam logic [1:0] ARS_SHOT_NONE = 2'h0;
	localparam logic [1:0] ARS_SHOT_1 = 2'h1;
	localparam logic [1:0] ARS_SHOT_2 = 2'h2;
	localparam logic [1:0] ARS_SHOT_3 = 2'h3;

	// Interrupt event bit positions
	localparam int ARS_EV_SHOT = 0;
	localparam int ARS_EV_RECLOSE = 1;
	localparam int ARS_EV_LOCKOUT = 2;
	localparam int ARS_EV_DONE = 3;
	localparam int ARS_NEV = 4;

	// Control register layout, bit 31 downward
	typedef struct packed {
		logic [23:0] unused;
		logic disable_by_highset_stage;
		logic fast_stage_shot3_block;
		logic fast_stage_shot2_block;
		logic block_shot23_by_fast_stage;
		logic block_shot1_by_fast_stage;
		logic [1:0] shots;
		logic enable;
	} ars_ctrl_t;

	localparam ars_ctrl_t ARS_CTRL_RST = '{unused: 24'h000000,
		disable_by_highset_stage: 1'b0, fast_stage_shot3_block: 1'b0,
		fast_stage_shot2_block: 1'b0, block_shot23_by_fast_stage: 1'b0,
		block_shot1_by_fast_stage: 1'b0, shots: 2'h3, enable: 1'b1};

	// Trip and pickup signals from the protection elements
	typedef struct packed {
		logic delayed_phase_overcurrent_stage;
		logic fast_phase_overcurrent_stage;
		logic highset_phase_overcurrent_stage;
		logic delayed_earth_fault_stage;
		logic phase_pickup;
		logic earth_pickup;
	} ars_trips_t;

	typedef enum logic [2:0] {
		ARS_IDLE,
		ARS_DEAD,
		ARS_RECLAIM,
		ARS_LOCKOUT
	} ars_state_t;

endpackage

/* File: hw/ars_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module ars_tick #(
	parameter int DIV = 50000
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	output logic tick
);
	import ars_pkg::*;

	initial begin
		if (DIV < 1 || DIV > 1048576) begin
			$error("ars_tick: DIV out of range");
		end
	end

	typedef struct packed {
		logic [19:0] cnt;
		logic tick;
	} ars_tick_st_t;

	ars_tick_st_t s_r;
	ars_tick_st_t s_nxt;

	// Free running divider; tick is a one-cycle pulse every DIV cycles
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (s_r.cnt == 20'(DIV - 1)) begin
			s_nxt.cnt = 20'h00000;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 20'h00001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_r <= '0;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.tick;
endmodule
`default_nettype wire

/* File: hw/ars_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module ars_timer #(
	parameter int W = 20
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic tick,
	input wire logic start,
	input wire logic stop,
	input wire logic [W-1:0] limit,
	output logic expired
);
	initial begin
		if (W < 2 || W > 31) begin
			$error("ars_timer: W out of range");
		end
	end

	typedef struct packed {
		logic [W-1:0] cnt;
		logic run;
		logic done;
	} ars_timer_st_t;

	ars_timer_st_t s_r;
	ars_timer_st_t s_nxt;

	// Start always restarts from zero, even while already running
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		if (start) begin
			s_nxt.cnt = '0;
			s_nxt.run = 1'b1;
		end else if (stop) begin
			s_nxt.run = 1'b0;
		end else if (s_r.run && tick) begin
			s_nxt.cnt = s_r.cnt + W'(1);
			// A zero limit expires on the first tick
			if (s_nxt.cnt >= limit) begin
				s_nxt.run = 1'b0;
				s_nxt.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_r <= '0;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign expired = s_r.done;
endmodule
`default_nettype wire

/* File: hw/ars_seq.sv */
// Behaviour
// - Separate switches block fast stage in shot 2 and in shot 3
// - Shot initiation activates fast stage blocking
// - Delayed trip advances shots, then definite trip
// - Dead time expiry starts cutout and reclaim
// - Cutout expiry releases blocking, reset independent
// - Phase and earth pickups may initiate shots
// - Own pickup delays; expiry opens breaker
// - Pickup initiation only shot one, definite trip; code ignores pickup expiry in reclaim while shots remain
// - Pickup delays reset to three hundred seconds
// - Pickups always routed; expiry trips breaker; code ignores expiry in reclaim while shots remain
// - Fast trip switch skips shot one
// - Fast trip switch stops shots two, three
// - Highset trip switch disables reclosing entirely
// - Three shots, delayed stage: shots 1,2,3
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ars_seq #(
	parameter int TICK_CYC = 50000
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire ars_pkg::ars_trips_t trips,
	output logic breaker_open_command,
	output logic breaker_reclose_command,
	output logic fast_stage_blocked,
	output logic irq
);
	import ars_pkg::*;

	initial begin
		if (TICK_CYC < 1) begin
			$error("ars_seq: TICK_CYC must be positive");
		end
	end

	typedef struct packed {
		ars_ctrl_t ctrl;
		logic [ARS_TW-1:0] dead;
		logic [ARS_TW-1:0] reclaim;
		logic [ARS_TW-1:0] cutout;
		logic [ARS_TW-1:0] ph_dly;
		logic [ARS_TW-1:0] ef_dly;
		logic [ARS_NEV-1:0] irq_stat;
		logic [ARS_NEV-1:0] irq_en;
		ars_state_t st;
		logic [1:0] shot;
		logic blk;
		logic open;
		logic reclose;
		logic ph_prev;
		logic ef_prev;
		logic ack;
		logic [31:0] rdata;
	} ars_seq_st_t;

	ars_seq_st_t s_r;
	ars_seq_st_t s_nxt;

	logic tick;
	logic start_dead;
	logic start_after;
	logic start_ph;
	logic start_ef;
	logic dead_exp;
	logic reclaim_exp;
	logic cutout_exp;
	logic ph_exp;
	logic ef_exp;

	// Byte lane merge for partial Avalon writes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// One common tick for every sequence timer
	ars_tick #(.DIV(TICK_CYC)) u_tick (
		.clk_sys(clk_sys),
		.reset(reset),
		.clk_en(clk_en),
		.tick(tick)
	);

	ars_timer #(.W(ARS_TW)) u_dead (
		.clk_sys(clk_sys),
		.reset(reset),
		.clk_en(clk_en),
		.tick(tick),
		.start(start_dead),
		.stop(1'b0),
		.limit(s_r.dead),
		.expired(dead_exp)
	);

	ars_timer #(.W(ARS_TW)) u_reclaim (
		.clk_sys(clk_sys),
		.reset(reset),
		.clk_en(clk_en),
		.tick(tick),
		.start(start_after),
		.stop(start_dead),
		.limit(s_r.reclaim),
		.expired(reclaim_exp)
	);

	ars_timer #(.W(ARS_TW)) u_cutout (
		.clk_sys(clk_sys),
		.reset(reset),
		.clk_en(clk_en),
		.tick(tick),
		.start(start_after),
		.stop(1'b0),
		.limit(s_r.cutout),
		.expired(cutout_exp)
	);

	// Pickup delay timers run only while their pickup stays up
	ars_timer #(.W(ARS_TW)) u_ph (
		.clk_sys(clk_sys),
		.reset(reset),
		.clk_en(clk_en),
		.tick(tick),
		.start(start_ph),
		.stop(!trips.phase_pickup),
		.limit(s_r.ph_dly),
		.expired(ph_exp)
	);

	ars_timer #(.W(ARS_TW)) u_ef (
		.clk_sys(clk_sys),
		.reset(reset),
		.clk_en(clk_en),
		.tick(tick),
		.start(start_ef),
		.stop(!trips.earth_pickup),
		.limit(s_r.ef_dly),
		.expired(ef_exp)
	);

	// Fast stage blocking: latched at initiation, plus per-shot switches
	always_comb begin
		fast_stage_blocked = 1'b0;
		if (s_r.st == ARS_DEAD || s_r.st == ARS_RECLAIM) begin
			fast_stage_blocked = s_r.blk
				|| (s_r.shot == ARS_SHOT_2
				&& s_r.ctrl.fast_stage_shot2_block)
				|| (s_r.shot == ARS_SHOT_3
				&& s_r.ctrl.fast_stage_shot3_block);
		end
	end

	// Pickup timers restart on the rising edge of each pickup
	assign start_ph = trips.phase_pickup && !s_r.ph_prev;
	assign start_ef = trips.earth_pickup && !s_r.ef_prev;

	// Sequencer, register file and bus slave in one next-state process
	always_comb begin
		logic [ARS_NEV-1:0] ev;
		logic fast_eff;
		logic slow_trip;
		logic pick_exp;
		logic go_shot;
		logic go_lock;
		logic [1:0] shot_to;
		logic bus_req;
		logic [31:0] rd;
		ev = '0;
		go_shot = 1'b0;
		go_lock = 1'b0;
		shot_to = ARS_SHOT_NONE;
		rd = 32'h00000000;
		bus_req = avs_read || avs_write;
		s_nxt = s_r;
		s_nxt.reclose = 1'b0;
		s_nxt.ph_prev = trips.phase_pickup;
		s_nxt.ef_prev = trips.earth_pickup;
		start_dead = 1'b0;
		start_after = 1'b0;
		// A blocked fast stage cannot trip again
		fast_eff = trips.fast_phase_overcurrent_stage && !fast_stage_blocked;
		slow_trip = trips.delayed_phase_overcurrent_stage
			|| trips.delayed_earth_fault_stage;
		pick_exp = ph_exp || ef_exp;

		case (s_r.st)
			ARS_IDLE: begin
				if (!s_r.ctrl.enable) begin
					go_shot = 1'b0;
				end else if (trips.highset_phase_overcurrent_stage
					&& s_r.ctrl.disable_by_highset_stage) begin
					go_lock = 1'b1;
				end else if (slow_trip || pick_exp
					|| (fast_eff
					&& !s_r.ctrl.block_shot1_by_fast_stage)) begin
					shot_to = ARS_SHOT_1;
					go_shot = 1'b1;
				end else if (fast_eff) begin
					shot_to = ARS_SHOT_2;
					go_shot = 1'b1;
				end
			end
			ARS_DEAD: begin
				// Breaker open: trips ignored until the reclose
				if (dead_exp) begin
					s_nxt.open = 1'b0;
					s_nxt.reclose = 1'b1;
					start_after = 1'b1;
					s_nxt.st = ARS_RECLAIM;
					ev[ARS_EV_RECLOSE] = 1'b1;
				end
			end
			ARS_RECLAIM: begin
				if (cutout_exp) begin
					s_nxt.blk = 1'b0;
				end
				if (trips.highset_phase_overcurrent_stage
					&& s_r.ctrl.disable_by_highset_stage) begin
					go_lock = 1'b1;
				end else if (s_r.shot >= s_r.ctrl.shots) begin
					// No shots left: a delayed or unblocked fast trip or pickup expiry is final
					go_lock = slow_trip || fast_eff || pick_exp;
				end else if (fast_eff
					&& s_r.ctrl.block_shot23_by_fast_stage) begin
					go_lock = 1'b1;
				end else if (slow_trip || fast_eff) begin
					shot_to = s_r.shot + ARS_SHOT_1;
					go_shot = 1'b1;
				end else if (reclaim_exp) begin
					s_nxt.st = ARS_IDLE;
					s_nxt.shot = ARS_SHOT_NONE;
					s_nxt.blk = 1'b0;
					ev[ARS_EV_DONE] = 1'b1;
				end
			end
			ARS_LOCKOUT: begin
				// Hold the breaker open until the fault is gone
				if (!(slow_trip || trips.fast_phase_overcurrent_stage
					|| trips.highset_phase_overcurrent_stage
					|| trips.phase_pickup || trips.earth_pickup)) begin
					s_nxt.st = ARS_IDLE;
					s_nxt.open = 1'b0;
					s_nxt.shot = ARS_SHOT_NONE;
					s_nxt.blk = 1'b0;
				end
			end
			default: begin
				s_nxt.st = ARS_IDLE;
			end
		endcase

		// Skipping to a shot beyond the set count means definite trip
		if (go_shot && shot_to > s_r.ctrl.shots) begin
			go_shot = 1'b0;
			go_lock = 1'b1;
		end
		if (go_shot) begin
			s_nxt.shot = shot_to;
			s_nxt.open = 1'b1;
			s_nxt.blk = 1'b1;
			s_nxt.st = ARS_DEAD;
			start_dead = 1'b1;
			ev[ARS_EV_SHOT] = 1'b1;
		end
		if (go_lock) begin
			s_nxt.open = 1'b1;
			s_nxt.blk = 1'b0;
			s_nxt.st = ARS_LOCKOUT;
			ev[ARS_EV_LOCKOUT] = 1'b1;
		end

		// Read mux; unmapped and write-only offsets read as zero
		case (avs_address)
			ARS_REG_CTRL: rd = s_r.ctrl;
			ARS_REG_DEAD: rd = 32'(s_r.dead);
			ARS_REG_RECLAIM: rd = 32'(s_r.reclaim);
			ARS_REG_CUTOUT: rd = 32'(s_r.cutout);
			ARS_REG_PH_DLY: rd = 32'(s_r.ph_dly);
			ARS_REG_EF_DLY: rd = 32'(s_r.ef_dly);
			ARS_REG_STATUS: rd = {24'h000000, fast_stage_blocked, s_r.open,
				s_r.shot, 1'b0, s_r.st};
			ARS_REG_IRQ_STAT: rd = 32'(s_r.irq_stat);
			ARS_REG_IRQ_EN: rd = 32'(s_r.irq_en);
			default: rd = 32'h00000000;
		endcase

		// Sticky events; a new event wins over a clear in the same cycle
		s_nxt.irq_stat = s_r.irq_stat | ev;

		// Request waits one cycle, then completes with registered data
		s_nxt.ack = bus_req && !s_r.ack;
		if (bus_req && !s_r.ack) begin
			s_nxt.rdata = rd;
		end
		if (avs_write && s_r.ack) begin
			case (avs_address)
				ARS_REG_CTRL: s_nxt.ctrl =
					merge(s_r.ctrl, avs_writedata, avs_byteenable)
					& 32'h000000ff;
				ARS_REG_DEAD: s_nxt.dead = ARS_TW'(merge(32'(s_r.dead),
					avs_writedata, avs_byteenable));
				ARS_REG_RECLAIM: s_nxt.reclaim = ARS_TW'(merge(
					32'(s_r.reclaim), avs_writedata, avs_byteenable));
				ARS_REG_CUTOUT: s_nxt.cutout = ARS_TW'(merge(
					32'(s_r.cutout), avs_writedata, avs_byteenable));
				ARS_REG_PH_DLY: s_nxt.ph_dly = ARS_TW'(merge(
					32'(s_r.ph_dly), avs_writedata, avs_byteenable));
				ARS_REG_EF_DLY: s_nxt.ef_dly = ARS_TW'(merge(
					32'(s_r.ef_dly), avs_writedata, avs_byteenable));
				ARS_REG_IRQ_CLR: begin
					if (avs_byteenable[0]) begin
						s_nxt.irq_stat = (s_r.irq_stat
							& ~avs_writedata[ARS_NEV-1:0]) | ev;
					end
				end
				ARS_REG_IRQ_EN: begin
					if (avs_byteenable[0]) begin
						s_nxt.irq_en = avs_writedata[ARS_NEV-1:0];
					end
				end
				default: s_nxt.ack = 1'b0;
			endcase
		end
	end

	// Whole state registered at once; clk_en freezes everything
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_r <= '0;
			s_r.ctrl <= ARS_CTRL_RST;
			s_r.dead <= ARS_DEAD_RST;
			s_r.reclaim <= ARS_RECLAIM_RST;
			s_r.cutout <= ARS_CUTOUT_RST;
			s_r.ph_dly <= ARS_PICKUP_DLY_RST;
			s_r.ef_dly <= ARS_PICKUP_DLY_RST;
			s_r.st <= ARS_IDLE;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
	assign avs_readdata = s_r.rdata;
	assign breaker_open_command = s_r.open;
	assign breaker_reclose_command = s_r.reclose;
	assign irq = |(s_r.irq_stat & s_r.irq_en);
endmodule
`default_nettype wire

/* File: test/ars_breaker_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ars_breaker_model #(
	parameter int OP_CYC = 3
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic open_cmd,
	input wire logic close_cmd,
	output logic closed
);
	int cnt;

	// Trip coil must stay energised OP_CYC+1 cycles before contacts part
	always @(posedge clk_sys) begin
		if (reset) begin
			closed <= 1'b1;
			cnt <= 0;
		end else if (close_cmd) begin
			closed <= 1'b1;
			cnt <= 0;
		end else if (open_cmd) begin
			cnt <= cnt + 1;
			if (cnt >= OP_CYC) begin
				closed <= 1'b0;
			end
		end else begin
			cnt <= 0;
		end
	end
endmodule
`default_nettype wire

/* File: test/ars_seq_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ars_seq_chk #(
	parameter int TICK_CYC = 50000
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire ars_pkg::ars_trips_t trips,
	input wire logic breaker_open_command,
	input wire logic breaker_reclose_command,
	input wire logic irq
);
	import ars_pkg::*;

	// One clock domain, so one default clock and reset for all
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	a_wait_first: assert property ($rose(avs_read || avs_write)
		|-> avs_waitrequest) else $error("new request not stalled");
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("request stalled too long");
	a_wait_idle: assert property (!avs_read && !avs_write
		|-> !avs_waitrequest) else $error("stall without request");
	a_reclose_pulse: assert property (breaker_reclose_command
		|=> !breaker_reclose_command [*2]) else $error("reclose too long");
	a_reclose_closes: assert property (breaker_reclose_command
		|-> !breaker_open_command && $past(breaker_open_command))
		else $error("reclose without dead time");
	a_trip_opens: assert property (!breaker_open_command
		&& !breaker_reclose_command && trips.delayed_phase_overcurrent_stage
		|=> breaker_open_command) else $error("delayed trip ignored");
	a_open_falls: assert property ($fell(breaker_open_command)
		|-> breaker_reclose_command || $past(trips) == 6'h00)
		else $error("open released without cause");
	a_reset_quiet: assert property ($fell(reset) |-> !breaker_open_command
		&& !breaker_reclose_command && !irq) else $error("reset not quiet");
endmodule

bind ars_seq ars_seq_chk #(.TICK_CYC(TICK_CYC)) ars_seq_chk_inst (
	.clk_sys(clk_sys),
	.reset(reset),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest),
	.trips(trips),
	.breaker_open_command(breaker_open_command),
	.breaker_reclose_command(breaker_reclose_command),
	.irq(irq)
);
`default_nettype wire

/* File: test/ars_seq_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module ars_seq_tb_top;
	import ars_pkg::*;
	localparam int T = 4; // Short tick keeps timer runs brief
	localparam logic [5:0] DL = 6'h20;
	localparam logic [5:0] FS = 6'h10;
	localparam logic [5:0] HS = 6'h08;
	localparam logic [5:0] PP = 6'h02;
	localparam logic [5:0] EP = 6'h01;
	logic clk_sys, reset, avs_read, avs_write, avs_waitrequest;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q, r;
	logic [3:0] avs_byteenable;
	ars_trips_t trips;
	logic opn, rcl, blk, irq, closed;
	int errors, checks_done, cyc_cnt, c, k;

	ars_seq #(.TICK_CYC(T)) ars_seq_inst (.clk_sys(clk_sys), .reset(reset),
		.clk_en(1'b1), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .trips(trips),
		.breaker_open_command(opn), .breaker_reclose_command(rcl),
		.fast_stage_blocked(blk), .irq(irq));
	ars_breaker_model #(.OP_CYC(3)) ars_breaker_model_inst (
		.clk_sys(clk_sys), .reset(reset), .open_cmd(opn),
		.close_cmd(rcl), .closed(closed));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
	endfunction

	// Expected status word from state, shot, open and blocking
	function automatic logic [31:0] st(input logic [2:0] s,
		input logic [1:0] n, input logic o, input logic b);
		return {24'h0, b, o, n, 1'b0, s};
	endfunction

	task summarize();
		$display("errors=%0d checks=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Avalon access; the global timeout ends a slave that never answers
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task tr(input logic [5:0] v);
		@(posedge clk_sys);
		trips <= v;
	endtask

	task wopen();
		c = 0;
		while (opn !== 1'b1) begin
			@(posedge clk_sys);
			c++;
		end
	endtask

	task wrcl();
		while (rcl !== 1'b1) @(posedge clk_sys);
	endtask

	// Hang guard
	always @(posedge clk_sys) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			errors++;
			summarize();
		end
	end

	initial begin
		reset = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 6'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		trips = 6'h00;
		errors = 0;
		checks_done = 0;
		cyc_cnt = 0;
		r = 32'h0001312c;
		wt(10);
		reset <= 1'b0;
		bus(0, ARS_REG_PH_DLY, 32'h0);
		`CHK(q, 32'h000493e0)
		bus(0, ARS_REG_EF_DLY, 32'h0);
		`CHK(q, 32'h000493e0)
		bus(0, ARS_REG_CTRL, 32'h0);
		`CHK(q, 32'h00000007)
		// Random timer limits read back through the low 20 bits
		for (k = 0; k < 8; k++) begin
			r = lfsr(r);
			bus(1, 6'(4 + 4 * (k % 5)), r);
			bus(0, 6'(4 + 4 * (k % 5)), 32'h0);
			`CHK(q, {12'h0, r[19:0]})
		end
		bus(1, 6'h28, r);
		bus(0, 6'h28, 32'h0);
		`CHK(q, 32'h0)
		// Upper lanes start at zero, so a leaked lane 1 shows as ff, lane 2 as f
		bus(1, ARS_REG_DEAD, 32'h0);
		avs_byteenable <= 4'h1;
		bus(1, ARS_REG_DEAD, 32'hffffff06);
		avs_byteenable <= 4'hf;
		bus(0, ARS_REG_DEAD, 32'h0);
		`CHK(q, 32'h6)
		bus(1, ARS_REG_RECLAIM, 32'd40);
		bus(1, ARS_REG_CUTOUT, 32'd1); // Cutout far below reclaim
		bus(1, ARS_REG_PH_DLY, 32'd2);
		bus(1, ARS_REG_EF_DLY, 32'd5);
		bus(1, ARS_REG_IRQ_EN, 32'hf);
		// Three shots on a persisting delayed trip
		bus(1, ARS_REG_CTRL, 32'h67);
		tr(DL);
		wopen();
		`CHK(blk, 1'b1)
		`CHK(irq, 1'b1)
		for (k = 0; k < 3; k++) begin
			wrcl();
			`CHK(blk, 1'b1)
			wt(1);
		end
		wt(4);
		bus(0, ARS_REG_STATUS, 32'h0);
		`CHK(q & 32'h7f, st(3'h3, 2'h3, 1'b1, 1'b0))
		`CHK(closed, 1'b0)
		tr(6'h00);
		wt(4);
		bus(1, ARS_REG_IRQ_CLR, 32'hf);
		bus(0, ARS_REG_IRQ_STAT, 32'h0);
		`CHK(q, 32'h0)
		// Cutout frees blocking while reclaim still runs; irq masked
		bus(1, ARS_REG_IRQ_EN, 32'h0);
		bus(1, ARS_REG_CTRL, 32'h67); // Shot 2 and 3 blocking switches on
		tr(DL);
		wopen();
		tr(6'h00);
		wrcl();
		wt(3 * T);
		`CHK(blk, 1'b0)
		`CHK(irq, 1'b0)
		bus(0, ARS_REG_STATUS, 32'h0);
		`CHK(q[2:0], 3'h2)
		bus(0, ARS_REG_IRQ_STAT, 32'h0);
		`CHK(q[1:0], 2'h3)
		bus(1, ARS_REG_IRQ_EN, 32'hf);
		wt(1); // Enable lands at the edge that ends the write
		`CHK(irq, 1'b1)
		bus(1, ARS_REG_IRQ_CLR, 32'hf);
		// Shot 2 keeps the fast stage blocked after cutout expiry
		tr(DL);
		wopen();
		tr(6'h00);
		wrcl();
		wt(3 * T);
		`CHK(blk, 1'b1)
		wt(45 * T);
		// Pickup start of shot one; later pickups are ignored
		tr(PP);
		wopen();
		`CHK(c >= T && c <= 3 * T + 4, 1'b1)
		tr(6'h00);
		wrcl();
		tr(EP);
		wt(8 * T);
		`CHK(opn, 1'b0)
		tr(6'h00);
		wt(45 * T);
		// One shot only: a pickup in reclaim is a definite trip
		bus(1, ARS_REG_CTRL, 32'h03);
		tr(EP);
		wopen();
		`CHK(c >= 4 * T && c <= 6 * T + 4, 1'b1)
		tr(6'h00);
		wrcl();
		tr(PP);
		wopen();
		bus(0, ARS_REG_STATUS, 32'h0);
		`CHK(q[2:0], 3'h3)
		tr(6'h00);
		wt(4);
		// Fast trip skips shot one
		bus(1, ARS_REG_CTRL, 32'h0f);
		tr(FS);
		wopen();
		bus(0, ARS_REG_STATUS, 32'h0);
		`CHK(q[5:4], 2'h2)
		tr(6'h00);
		wrcl();
		wt(3 * T);
		`CHK(blk, 1'b0)
		wt(45 * T);
		// High-set trip disables reclosing
		bus(1, ARS_REG_CTRL, 32'h87);
		tr(HS);
		wopen();
		wt(8 * T);
		bus(0, ARS_REG_STATUS, 32'h0);
		`CHK(q[2:0], 3'h3)
		tr(6'h00);
		wt(4);
		// Fast trip in reclaim ends the sequence
		bus(1, ARS_REG_CTRL, 32'h17);
		tr(DL);
		wopen();
		tr(6'h00);
		wrcl();
		tr(FS);
		wt(4);
		bus(0, ARS_REG_STATUS, 32'h0);
		`CHK(q[2:0], 3'h3)
		tr(6'h00);
		wt(4);
		summarize();
	end
endmodule
`default_nettype wire
